// ---- sim/ecif_encoder_model.sv ----
// Behavioural encoder driving the three counting tracks
`timescale 1ns/10ps
module ecif_encoder_model (
  input  wire logic sys_clk_i,
  output logic      track_a_o = 1'b0,
  output logic      track_b_o = 1'b0,
  output logic      track_n_o = 1'b0
);
  int ph = 0;
  // Phase 0..3; A leads B going up, N marks phase 1 once every four steps
  task automatic quad(input bit up, input int n, input int hold);
    repeat (n) begin
      ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
      track_a_o <= (ph == 1 || ph == 2);
      track_b_o <= (ph >= 2);
      track_n_o <= (ph == 1);
      repeat (hold) @(posedge sys_clk_i);
    end
  endtask
  // Equal high and low times keep the duty at 50:50
  task automatic pulse(input bit on_b, input int n, input int hold);
    repeat (n) begin
      if (on_b) track_b_o <= 1'b1; else track_a_o <= 1'b1;
      repeat (hold) @(posedge sys_clk_i);
      if (on_b) track_b_o <= 1'b0; else track_a_o <= 1'b0;
      repeat (hold) @(posedge sys_clk_i);
    end
  endtask
  // Both tracks pulse together: opposite edges in the same cycle
  task automatic pair(input int n, input int hold);
    repeat (n) begin
      track_a_o <= 1'b1;
      track_b_o <= 1'b1;
      repeat (hold) @(posedge sys_clk_i);
      track_a_o <= 1'b0;
      track_b_o <= 1'b0;
      repeat (hold) @(posedge sys_clk_i);
    end
  endtask
  task automatic level_b(input logic v);
    track_b_o <= v;
    repeat (600) @(posedge sys_clk_i);
  endtask
  task automatic glitch(input int w);
    track_a_o <= ~track_a_o;
    repeat (w) @(posedge sys_clk_i);
    track_a_o <= ~track_a_o;
    repeat (600) @(posedge sys_clk_i);
  endtask
endmodule

// ---- sim/ecif_top_sva.sv ----
// Port assertions for the encoder count front end
`timescale 1ns/10ps
module ecif_top_sva #(
  parameter int CNT_W = ecif_pkg::CNT_W
) (
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        count_up_o,
  input wire logic        count_down_o,
  input wire logic        zero_mark_o,
  input wire logic        switch_output_0_o,
  input wire logic        switch_output_1_o,
  input wire logic        cmp_match_0_i,
  input wire logic        cmp_match_1_i,
  input wire logic        supply_ok_i,
  input wire logic        sensor_supply_short_i,
  input wire logic        sensor_supply_overload_i,
  input wire logic        supply_fault_o,
  input wire logic        sensor_supply_fault_o
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic       sw0_exp;
  logic       sw1_exp;
  logic       zero_ok;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Shadow of the control byte, mirrored from the bus writes
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_i && addr_i == ecif_pkg::ADDR_CTRL) ctrl_next = wdata_i[7:0];
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) ctrl_reg <= 8'h00;
    else ctrl_reg <= ctrl_next;
  end
  assign sw0_exp = ctrl_reg[ecif_pkg::CTRL_DQ0_AUTO] ? cmp_match_0_i
                                                     : ctrl_reg[ecif_pkg::CTRL_DQ0_SET];
  assign sw1_exp = ctrl_reg[ecif_pkg::CTRL_DQ1_AUTO] ? cmp_match_1_i
                                                     : ctrl_reg[ecif_pkg::CTRL_DQ1_SET];
  assign zero_ok = (ctrl_reg[2:0] == 3'h4);
  sequence s_count;
    count_up_o || count_down_o;
  endsequence
  sequence s_quiet;
    !(count_up_o || count_down_o) [*8];
  endsequence
  chk_count_excl: assert property (!(count_up_o && count_down_o))
    else $error("up and down pulse together");
  chk_count_spacing: assert property (s_count |=> s_quiet)
    else $error("count pulses closer than the filter allows");
  chk_sw0_source: assert property (!$past(srst_i) |->
    switch_output_0_o == $past(sw0_exp))
    else $error("output 0 wrong source");
  chk_sw1_source: assert property (!$past(srst_i) |->
    switch_output_1_o == $past(sw1_exp))
    else $error("output 1 wrong source");
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  chk_ctrl_readback: assert property (rd_i && addr_i == ecif_pkg::ADDR_CTRL |=>
    rdata_o[7:0] == $past(ctrl_reg))
    else $error("control readback wrong");
  chk_supply_flag: assert property ((!supply_ok_i) [*6] |=> supply_fault_o)
    else $error("missing supply not flagged");
  chk_sensor_flag: assert property
    ((sensor_supply_short_i || sensor_supply_overload_i) [*6] |=> sensor_supply_fault_o)
    else $error("sensor supply fault not flagged");
  chk_zero_mode: assert property (zero_mark_o |-> $past(zero_ok))
    else $error("zero mark outside quad zero mode");
endmodule

bind ecif_top ecif_top_sva #(.CNT_W(CNT_W)) u_sva (
  .sys_clk_i                (sys_clk_i),
  .srst_i                   (srst_i),
  .addr_i                   (addr_i),
  .wdata_i                  (wdata_i),
  .wr_i                     (wr_i),
  .rd_i                     (rd_i),
  .rdata_o                  (rdata_o),
  .count_up_o               (count_up_o),
  .count_down_o             (count_down_o),
  .zero_mark_o              (zero_mark_o),
  .switch_output_0_o        (switch_output_0_o),
  .switch_output_1_o        (switch_output_1_o),
  .cmp_match_0_i            (cmp_match_0_i),
  .cmp_match_1_i            (cmp_match_1_i),
  .supply_ok_i              (supply_ok_i),
  .sensor_supply_short_i    (sensor_supply_short_i),
  .sensor_supply_overload_i (sensor_supply_overload_i),
  .supply_fault_o           (supply_fault_o),
  .sensor_supply_fault_o    (sensor_supply_fault_o)
);

// ---- sim/test_ecif_top.sv ----
// Self-checking bench for the encoder count front end
`timescale 1ns/10ps
module test_ecif_top;
  logic        sys_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        track_a_i, track_b_i, track_n_i;
  logic        aux_input_0_i = 1'b0, aux_input_1_i = 1'b0, aux_input_2_i = 1'b0;
  logic        supply_ok_i = 1'b1;
  logic        sensor_supply_short_i = 1'b0, sensor_supply_overload_i = 1'b0;
  logic        cmp_match_0_i = 1'b0, cmp_match_1_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0, rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic        count_up_o, count_down_o, zero_mark_o, switch_output_0_o, switch_output_1_o;
  logic        supply_fault_o, sensor_supply_fault_o;
  logic [2:0]  aux_level_o;
  logic [15:0] lf = 16'h39FD;
  int          failures = 0, n_checks = 0, n_up = 0, n_dn = 0, n_z = 0, cyc = 0;
  ecif_top DUT (
    .sys_clk_i                (sys_clk_i),
    .srst_i                   (srst_i),
    .track_a_i                (track_a_i),
    .track_b_i                (track_b_i),
    .track_n_i                (track_n_i),
    .aux_input_0_i            (aux_input_0_i),
    .aux_input_1_i            (aux_input_1_i),
    .aux_input_2_i            (aux_input_2_i),
    .supply_ok_i              (supply_ok_i),
    .sensor_supply_short_i    (sensor_supply_short_i),
    .sensor_supply_overload_i (sensor_supply_overload_i),
    .cmp_match_0_i            (cmp_match_0_i),
    .cmp_match_1_i            (cmp_match_1_i),
    .addr_i                   (addr_i),
    .wdata_i                  (wdata_i),
    .wr_i                     (wr_i),
    .rd_i                     (rd_i),
    .rdata_o                  (rdata_o),
    .count_up_o               (count_up_o),
    .count_down_o             (count_down_o),
    .zero_mark_o              (zero_mark_o),
    .aux_level_o              (aux_level_o),
    .switch_output_0_o        (switch_output_0_o),
    .switch_output_1_o        (switch_output_1_o),
    .supply_fault_o           (supply_fault_o),
    .sensor_supply_fault_o    (sensor_supply_fault_o)
  );
  ecif_encoder_model enc (.sys_clk_i(sys_clk_i), .track_a_o(track_a_i),
                          .track_b_o(track_b_i), .track_n_o(track_n_i));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", rdata_o, e);
    @(posedge sys_clk_i);
  endtask
  always @(posedge sys_clk_i) begin
    n_up += int'(count_up_o === 1'b1);
    n_dn += int'(count_down_o === 1'b1);
    n_z += int'(zero_mark_o === 1'b1);
    cyc++;
    if (cyc == 70000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    wait_clk(20);
    srst_i <= 1'b0;
    rd(ecif_pkg::ADDR_CTRL, ecif_pkg::CTRL_RESET);
    rd(ecif_pkg::ADDR_FILT, 32'(ecif_pkg::FILT_RESET));
    rd(ecif_pkg::ADDR_DELAY, 32'(ecif_pkg::DELAY_RESET));
    rd(8'h14, 32'h0);
    wr(ecif_pkg::ADDR_FILT, 32'hF);
    rd(ecif_pkg::ADDR_FILT, 32'hF);
    wr(ecif_pkg::ADDR_CTRL, 32'h4);
    enc.quad(1'b1, 8, 600);
    enc.quad(1'b0, 4, 600);
    chk("quad up", n_up, 8);
    chk("quad down", n_dn, 4);
    chk("zero", n_z, 3);
    rd(ecif_pkg::ADDR_COUNT, 32'h4);
    wr(ecif_pkg::ADDR_CTRL, 32'h104);
    rd(ecif_pkg::ADDR_COUNT, 32'h0);
    lf = nx(lf);
    enc.glitch(int'(lf[8:0]) % 450 + 1);
    chk("glitch", n_up + n_dn, 12);
    wr(ecif_pkg::ADDR_CTRL, 32'h1);
    enc.pulse(1'b0, 3, 600);
    enc.pulse(1'b1, 2, 600);
    wr(ecif_pkg::ADDR_CTRL, 32'h9);
    enc.pulse(1'b0, 2, 600);
    chk("pulse up", n_up, 11);
    chk("pulse down", n_dn, 6);
    wr(ecif_pkg::ADDR_CTRL, 32'h2);
    enc.pulse(1'b0, 2, 600);
    enc.level_b(1'b1);
    enc.pulse(1'b0, 2, 600);
    enc.level_b(1'b0);
    chk("dir up", n_up, 13);
    chk("dir down", n_dn, 8);
    wr(ecif_pkg::ADDR_CTRL, 32'h3);
    enc.pulse(1'b0, 3, 600);
    enc.pulse(1'b1, 2, 600);
    chk("updown up", n_up, 16);
    chk("updown down", n_dn, 10);
    enc.pair(2, 600);
    chk("updown pair", n_up + n_dn, 26);
    rd(ecif_pkg::ADDR_COUNT, 32'h2);
    wr(ecif_pkg::ADDR_DELAY, 32'h0);
    repeat (6) begin
      lf = nx(lf);
      {aux_input_2_i, aux_input_1_i, aux_input_0_i} <= lf[2:0];
      wait_clk(6);
      #1 chk("aux", aux_level_o, lf[2:0]);
      wait_clk(1);
    end
    {aux_input_2_i, aux_input_1_i, aux_input_0_i} <= 3'h0;
    wait_clk(6);
    wr(ecif_pkg::ADDR_DELAY, 32'h1);
    {aux_input_2_i, aux_input_1_i, aux_input_0_i} <= 3'h7;
    wait_clk(5000);
    {aux_input_2_i, aux_input_1_i, aux_input_0_i} <= 3'h0;
    wait_clk(1000);
    #1 chk("aux short", aux_level_o, 3'h0);
    wait_clk(1);
    {aux_input_2_i, aux_input_1_i, aux_input_0_i} <= 3'h7;
    wait_clk(12000);
    #1 chk("aux early", aux_level_o, 3'h0);
    wait_clk(700);
    #1 chk("aux late", aux_level_o, 3'h7);
    wait_clk(1);
    repeat (8) begin
      lf = nx(lf);
      {cmp_match_1_i, cmp_match_0_i} <= lf[1:0];
      wr(ecif_pkg::ADDR_CTRL, {24'h0, lf[7:4], 4'h0});
      wait_clk(2);
      #1 chk("sw0", switch_output_0_o, lf[4] ? lf[0] : lf[6]);
      chk("sw1", switch_output_1_o, lf[5] ? lf[1] : lf[7]);
      wait_clk(1);
    end
    repeat (8) begin
      lf = nx(lf);
      {supply_ok_i, sensor_supply_short_i, sensor_supply_overload_i} <= lf[10:8];
      wait_clk(8);
      #1 chk("supply", supply_fault_o, !lf[10]);
      chk("sensor", sensor_supply_fault_o, lf[9] | lf[8]);
      wait_clk(1);
    end
    rd(ecif_pkg::ADDR_STATUS, {21'h0, 3'h7, lf[9] | lf[8], 1'b0, !lf[10], 5'h00});
    summarize();
  end
endmodule

// ---- src/ecif_pkg.sv ----
// Package with constants for the encoder count input front end
package ecif_pkg;

  // Register map (word aligned byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_FILT   = 8'h04;
  localparam logic [7:0] ADDR_DELAY  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_COUNT  = 8'h10;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ZERO_EN  = 2;
  localparam int CTRL_DIR_DOWN = 3;
  localparam int CTRL_DQ0_AUTO = 4;
  localparam int CTRL_DQ1_AUTO = 5;
  localparam int CTRL_DQ0_SET  = 6;
  localparam int CTRL_DQ1_SET  = 7;
  localparam int CTRL_CLR      = 8;

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [3:0]  FILT_RESET  = 4'hA;
  localparam logic [3:0]  DELAY_RESET = 4'h2;

  // Counting modes
  localparam logic [1:0] MODE_QUAD   = 2'h0;
  localparam logic [1:0] MODE_PULSE  = 2'h1;
  localparam logic [1:0] MODE_PDIR   = 2'h2;
  localparam logic [1:0] MODE_UPDOWN = 2'h3;

  localparam int CLK_MHZ = 250;

  // Filter minimum times in ns, step 0 = 100 Hz ... step 10 = 200 kHz
  localparam int FILT_STEPS = 11;
  localparam int FILT_NS [FILT_STEPS] = '{4000000, 2000000, 800000, 400000, 200000,
                                          80000, 40000, 20000, 8000, 4000, 2000};
  // Aux input delays in ns, step 0 = none
  localparam int DELAY_STEPS = 9;
  localparam int DELAY_NS [DELAY_STEPS] = '{0, 50000, 100000, 400000, 800000,
                                            1600000, 3200000, 12800000, 20000000};

  localparam int CNT_W = 23;

endpackage

// ---- src/ecif_top.sv ----
// Encoder count input front end: filters, decoder, aux inputs, outputs
//
// Behaviour
// R1: Quadrature mode decodes count and direction
// R2: Optional zero mark on third input
// R3: Pulse mode, direction from control bit
// R4: Pulse mode, B level selects direction
// R5: Up/down mode, A up, B down
// R6: Wire-break switching may disturb count
// R7: Filter rejects changes shorter than minimum
// R8: Eleven filter steps, 200 kHz default
// R9: Encoder keeps duty within 40:60..60:40
// R10: Three aux inputs for gate/sync/capture; here they are only delayed and their levels reported
// R11: Aux input levels always reported
// R12: Aux change accepted after stable delay
// R13: Aux delay none..20 ms, 0.1 ms default
// R14: Outputs by compare or program
// R15: Report missing main supply
// R16: Flag encoder supply short or overload
// R17: Control applies next cycle, status latched
// R18: Synchronise all inputs before filtering
// R19: Lead counts up, double transitions ignored
`timescale 1ns/10ps
module ecif_top #(
  parameter int CNT_W = ecif_pkg::CNT_W
) (
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        track_a_i,
  input  wire logic        track_b_i,
  input  wire logic        track_n_i,
  input  wire logic        aux_input_0_i,
  input  wire logic        aux_input_1_i,
  input  wire logic        aux_input_2_i,
  input  wire logic        supply_ok_i,
  input  wire logic        sensor_supply_short_i,
  input  wire logic        sensor_supply_overload_i,
  input  wire logic        cmp_match_0_i,
  input  wire logic        cmp_match_1_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             count_up_o,
  output logic             count_down_o,
  output logic             zero_mark_o,
  output logic      [2:0]  aux_level_o,
  output logic             switch_output_0_o,
  output logic             switch_output_1_o,
  output logic             supply_fault_o,
  output logic             sensor_supply_fault_o
);

  function automatic logic [CNT_W-1:0] filt_cycles(input logic [3:0] sel);
    int idx;
    idx = (int'(sel) < ecif_pkg::FILT_STEPS) ? int'(sel) : ecif_pkg::FILT_STEPS - 1;
    // Least time rounds up to whole cycles
    return CNT_W'((ecif_pkg::FILT_NS[idx] * ecif_pkg::CLK_MHZ + 999) / 1000);
  endfunction

  function automatic logic [CNT_W-1:0] delay_cycles(input logic [3:0] sel);
    int idx;
    idx = (int'(sel) < ecif_pkg::DELAY_STEPS) ? int'(sel) : ecif_pkg::DELAY_STEPS - 1;
    return CNT_W'((ecif_pkg::DELAY_NS[idx] / 1000) * ecif_pkg::CLK_MHZ);
  endfunction

  // Two-stage synchronisers for all pin inputs
  localparam int NIN = 9;
  // Supply-ok idles high, so no false supply fault follows reset
  localparam logic [NIN-1:0] PIN_IDLE = 9'h040;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  assign pin_raw = {sensor_supply_overload_i, sensor_supply_short_i, supply_ok_i,
                    aux_input_2_i, aux_input_1_i, aux_input_0_i,
                    track_n_i, track_b_i, track_a_i};
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sync1_reg <= PIN_IDLE;
      sync2_reg <= PIN_IDLE;
    end else begin
      sync1_reg <= pin_raw; // R18
      sync2_reg <= sync1_reg; // R18
    end
  end

  // Register file
  logic [31:0] ctrl_reg, ctrl_next;
  logic [3:0]  filt_reg, filt_next;
  logic [3:0]  delay_reg, delay_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [CNT_W-1:0] filt_lim;
  logic [CNT_W-1:0] delay_lim;
  logic [31:0] count_reg, count_next;
  logic [31:0] count_cap_reg, count_cap_next;

  // Six filtered/debounced channels: A, B, N, then three aux inputs
  logic [5:0] filt_out_reg;
  logic [5:0] filt_prev_reg;
  logic [2:0] faults_reg, faults_next;

  assign filt_lim  = filt_cycles(filt_reg); // R8
  assign delay_lim = delay_cycles(delay_reg); // R13

  always_comb begin
    ctrl_next      = ctrl_reg;
    filt_next      = filt_reg;
    delay_next     = delay_reg;
    rdata_next     = 32'h0000_0000;
    count_cap_next = count_cap_reg;
    ctrl_next[ecif_pkg::CTRL_CLR] = 1'b0;
    if (wr_i) begin // R17
      if (addr_i == ecif_pkg::ADDR_CTRL) begin
        ctrl_next = wdata_i;
      end else if (addr_i == ecif_pkg::ADDR_FILT) begin
        filt_next = wdata_i[3:0];
      end else if (addr_i == ecif_pkg::ADDR_DELAY) begin
        delay_next = wdata_i[3:0];
      end
    end
    if (rd_i) begin
      if (addr_i == ecif_pkg::ADDR_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (addr_i == ecif_pkg::ADDR_FILT) begin
        rdata_next = {28'h0000000, filt_reg};
      end else if (addr_i == ecif_pkg::ADDR_DELAY) begin
        rdata_next = {28'h0000000, delay_reg};
      end else if (addr_i == ecif_pkg::ADDR_STATUS) begin
        rdata_next = {24'h000000, faults_reg, filt_out_reg[2:0], 2'b00}; // R11
        rdata_next[10:8] = filt_out_reg[5:3]; // R11
      end else if (addr_i == ecif_pkg::ADDR_COUNT) begin
        rdata_next = count_reg; // R17
      end
    end
    // Snapshot taken on count read into count_cap_reg, which no register read returns
    if (rd_i && addr_i == ecif_pkg::ADDR_COUNT) begin
      count_cap_next = count_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_reg      <= ecif_pkg::CTRL_RESET;
      filt_reg      <= ecif_pkg::FILT_RESET;
      delay_reg     <= ecif_pkg::DELAY_RESET;
      rdata_reg     <= 32'h0000_0000;
      count_cap_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg      <= ctrl_next;
      filt_reg      <= filt_next;
      delay_reg     <= delay_next;
      rdata_reg     <= rdata_next;
      count_cap_reg <= count_cap_next;
    end
  end
  assign rdata_o = rdata_reg;

  // Stability filters: a new level is taken once it held for the limit
  logic [CNT_W-1:0] stab_cnt_reg  [6];
  logic [CNT_W-1:0] stab_cnt_next [6];
  logic [5:0]       filt_out_next;
  logic [5:0]       filt_in;
  assign filt_in = sync2_reg[5:0];

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_filt
      logic [CNT_W-1:0] lim;
      assign lim = (gi < 3) ? filt_lim : delay_lim;
      always_comb begin
        stab_cnt_next[gi] = '0;
        filt_out_next[gi] = filt_out_reg[gi];
        if (filt_in[gi] != filt_out_reg[gi]) begin
          // Delay "none" passes immediately
          if (stab_cnt_reg[gi] >= lim) begin // R7 R12
            filt_out_next[gi] = filt_in[gi];
          end else begin
            stab_cnt_next[gi] = stab_cnt_reg[gi] + 1'b1;
          end
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          stab_cnt_reg[gi] <= '0;
          filt_out_reg[gi] <= 1'b0;
        end else begin
          stab_cnt_reg[gi] <= stab_cnt_next[gi];
          filt_out_reg[gi] <= filt_out_next[gi];
        end
      end
    end
  endgenerate

  // Decoder
  logic [1:0] mode;
  logic       a_f, b_f, n_f, a_p, b_p, n_p;
  logic       up_next, dn_next, zero_next;
  logic       up_reg, dn_reg, zero_reg;
  assign mode = ctrl_reg[ecif_pkg::CTRL_MODE_LSB +: 2];
  assign a_f = filt_out_reg[0];
  assign b_f = filt_out_reg[1];
  assign n_f = filt_out_reg[2];
  assign a_p = filt_prev_reg[0];
  assign b_p = filt_prev_reg[1];
  assign n_p = filt_prev_reg[2];

  always_comb begin
    up_next    = 1'b0;
    dn_next    = 1'b0;
    zero_next  = 1'b0;
    count_next = count_reg;
    case (mode)
      ecif_pkg::MODE_QUAD: begin
        // Single-track change only; both at once is invalid
        if ((a_f != a_p) && (b_f == b_p)) begin // R1 R19
          up_next = (a_f != b_f);
          dn_next = (a_f == b_f);
        end else if ((b_f != b_p) && (a_f == a_p)) begin // R1 R19
          up_next = (a_f == b_f);
          dn_next = (a_f != b_f);
        end
      end
      ecif_pkg::MODE_PULSE: begin
        if (a_f && !a_p) begin // R3
          up_next = !ctrl_reg[ecif_pkg::CTRL_DIR_DOWN];
          dn_next = ctrl_reg[ecif_pkg::CTRL_DIR_DOWN];
        end
      end
      ecif_pkg::MODE_PDIR: begin
        if (a_f && !a_p) begin // R4
          up_next = !b_f;
          dn_next = b_f;
        end
      end
      default: begin
        up_next = a_f && !a_p; // R5
        dn_next = b_f && !b_p; // R5
      end
    endcase
    // Opposite edges in one cycle cancel, so neither pulse is shown
    if (up_next && dn_next) begin // R5
      up_next = 1'b0;
      dn_next = 1'b0;
    end
    if (mode == ecif_pkg::MODE_QUAD && ctrl_reg[ecif_pkg::CTRL_ZERO_EN]) begin
      zero_next = n_f && !n_p; // R2
    end
    // Push-pull wire-break toggling reaches here as ordinary edges
    if (ctrl_reg[ecif_pkg::CTRL_CLR]) begin
      count_next = 32'h0000_0000;
    end else if (up_next && !dn_next) begin // R6
      count_next = count_reg + 32'h0000_0001;
    end else if (dn_next && !up_next) begin
      count_next = count_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      filt_prev_reg <= '0;
      up_reg        <= 1'b0;
      dn_reg        <= 1'b0;
      zero_reg      <= 1'b0;
      count_reg     <= 32'h0000_0000;
    end else begin
      filt_prev_reg <= filt_out_reg;
      up_reg        <= up_next;
      dn_reg        <= dn_next;
      zero_reg      <= zero_next;
      count_reg     <= count_next;
    end
  end

  assign count_up_o   = up_reg;
  assign count_down_o = dn_reg;
  assign zero_mark_o  = zero_reg;
  assign aux_level_o  = filt_out_reg[5:3]; // R10 R11

  // Outputs and faults
  logic dq0_next, dq1_next, dq0_reg, dq1_reg;
  always_comb begin
    dq0_next = ctrl_reg[ecif_pkg::CTRL_DQ0_AUTO] ? cmp_match_0_i
                                                  : ctrl_reg[ecif_pkg::CTRL_DQ0_SET]; // R14
    dq1_next = ctrl_reg[ecif_pkg::CTRL_DQ1_AUTO] ? cmp_match_1_i
                                                  : ctrl_reg[ecif_pkg::CTRL_DQ1_SET]; // R14
    faults_next = {sync2_reg[8] | sync2_reg[7], // R16
                   1'b0,
                   !sync2_reg[6]}; // R15
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dq0_reg    <= 1'b0;
      dq1_reg    <= 1'b0;
      faults_reg <= 3'b000;
    end else begin
      dq0_reg    <= dq0_next;
      dq1_reg    <= dq1_next;
      faults_reg <= faults_next;
    end
  end

  assign switch_output_0_o     = dq0_reg;
  assign switch_output_1_o     = dq1_reg;
  assign supply_fault_o        = faults_reg[0];
  assign sensor_supply_fault_o = faults_reg[2];

endmodule
